/* File: src/kbm_mailbox.sv */
/*
  Keyboard controller host mailbox: host write FIFO, data/status
  mailbox, link pin drivers, power-down control, fast gate/reset port.
  Assumes host and controller strobes are one-cycle pulses on MCLK.
*/
`timescale 1ns/10ps
// Overview of operation
// - Keyboard clock/data pins driven by inverted port bits 6/7, read back.
// - Mouse clock/data pins driven by inverted port bits 3/2, read back.
// - All four link pins are open drain: pulled low or released.
// - Halt enters soft power-down; ALU clock stops, timer and interrupts run.
// - Soft power-down ends on reset or host write; may call the routine.
// - Reset exit restarts execution at program address zero.
// - Stop enters hard power-down with oscillator off; same exits.
// - Core gets only two interrupts: input full and timer overflow.
// - On-chip program store of 2K bytes and data RAM of 256 bytes.
// - Controller data write loads output buffer, sets flag, raises irq.
// - Controller data read returns oldest unread host byte, clears input-full unless more are queued.
// - Status: bit3 command/data, bit1 input-full, bit0 output-full, rest user.
// - Status clears on reset; host reads, controller reads and writes.
// - Each host write loads command/data from host address bit 2.
// - Host write sets input-full and irq; controller read clears both unless another byte is queued.
// - Output-full set by controller write, cleared by host data read.
// - Controller clock is 12 MHz derived from the 14.318 MHz reference.
// - External reset only; link pins to input, status to 00h.
// - Fast gate/reset port at 92h, default 24h, open only when enabled.
// - Port bit 1 sets the alternate address gate output level.
// - Writing one to port bit 0 gives one low pulse; rearm by zero.
// - With flag gating and port bit 4 set, output-full drives kbd irq.

module kbm_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } kbm_fifo_state_type;
  kbm_fifo_state_type r;
  kbm_fifo_state_type next_r;
  logic push;
  logic pop;

  assign in_ready = (r.cnt != (AW+1)'(DEPTH));
  assign out_valid = (r.cnt != '0);
  assign out_data = r.mem[r.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    next_r = r;
    if (push) begin
      next_r.mem[r.wp] = in_data;
      next_r.wp = (r.wp == AW'(DEPTH - 1)) ? '0 : r.wp + 1'b1;
    end
    if (pop) begin
      next_r.rp = (r.rp == AW'(DEPTH - 1)) ? '0 : r.rp + 1'b1;
    end
    if (push && !pop) begin
      next_r.cnt = r.cnt + 1'b1;
    end else if (pop && !push) begin
      next_r.cnt = r.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
endmodule : kbm_fifo

module kbm_mailbox
  import kbm_pkg::*;
#(
  parameter int FIFO_W = FIFO_WIDTH,
  parameter int FIFO_D = FIFO_DEPTH
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RESET_N,
  // Host side of the mailbox
  input wire logic HOST_WR,
  input wire logic HOST_RD,
  input wire logic HOST_ADDR2,
  input wire logic [7:0] HOST_WDATA,
  output logic HOST_WR_READY,
  output logic [7:0] HOST_RDATA,
  // Host side of the fast gate/reset port
  input wire logic HOST_FGR_WR,
  input wire logic HOST_FGR_RD,
  input wire logic [7:0] RESET_GATE_CONFIG,
  // Controller side of the mailbox
  input wire logic CTL_DATA_WR,
  input wire logic CTL_DATA_RD,
  input wire logic CTL_STATUS_WR,
  input wire logic [7:0] CTL_WDATA,
  output logic [7:0] CTL_IN_DATA,
  output logic [7:0] CTL_STATUS,
  input wire logic [7:0] CTL_PORT2,
  input wire logic EN_FLAGS,
  // Controller power and interrupts
  input wire logic HALT_REQ,
  input wire logic STOP_REQ,
  input wire logic IBF_IRQ_EN,
  input wire logic TMR_IRQ_EN,
  input wire logic TIMER_OVF,
  output logic ALU_CLK_EN,
  output logic OSC_EN,
  output logic WAKE_CALL,
  output logic CORE_START,
  output logic [10:0] CORE_PC,
  output logic IBF_IRQ,
  output logic TMR_IRQ,
  // Program store and data RAM
  input wire logic PROG_LOAD_WE,
  input wire logic [10:0] PROG_ADDR,
  input wire logic [7:0] PROG_WDATA,
  output logic [7:0] PROG_RDATA,
  input wire logic RAM_WE,
  input wire logic [7:0] RAM_ADDR,
  input wire logic [7:0] RAM_WDATA,
  output logic [7:0] RAM_RDATA,
  // Link pins
  input wire logic KBD_LINK_CLK_PIN_I,
  output logic KBD_LINK_CLK_PIN_O,
  output logic KBD_LINK_CLK_PIN_OE,
  input wire logic KBD_LINK_DATA_PIN_I,
  output logic KBD_LINK_DATA_PIN_O,
  output logic KBD_LINK_DATA_PIN_OE,
  input wire logic MOUSE_LINK_CLK_PIN_I,
  output logic MOUSE_LINK_CLK_PIN_O,
  output logic MOUSE_LINK_CLK_PIN_OE,
  input wire logic MOUSE_LINK_DATA_PIN_I,
  output logic MOUSE_LINK_DATA_PIN_O,
  output logic MOUSE_LINK_DATA_PIN_OE,
  // Pin readback to the core
  output logic TEST_INPUT_ZERO,
  output logic TEST_INPUT_ONE,
  output logic PORT_BIT_KBD_DATA_IN,
  output logic PORT_BIT_MOUSE_DATA_IN,
  // System outputs
  output logic KBD_IRQ_OUT,
  output logic MOUSE_IRQ_OUT,
  output logic ALT_ADDR20_GATE,
  output logic ALT_RESET_PULSE_N
);
  typedef struct packed {
    logic [7:0] obuf;
    logic [7:0] ibuf;
    logic cd;
    logic input_full_flag;
    logic output_full_flag;
    logic [3:0] ud_hi;
    logic ud2;
    logic [3:0] oe;
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [7:0] hrdata;
    logic a20;
    logic rst_bit;
    kbm_ars_type ars;
    logic [4:0] cnt;
    kbm_pwr_type pwr;
    logic wake;
    logic start;
  } kbm_state_type;

  kbm_state_type r;
  kbm_state_type next_r;
  logic [7:0] prog_mem [PROG_ROM_BYTES];
  logic [7:0] data_ram [DATA_RAM_BYTES];
  logic [7:0] prog_q;
  logic [7:0] ram_q;
  logic push;
  logic fifo_valid;
  logic fifo_take;
  logic [FIFO_W-1:0] fifo_data;
  logic fgr_open;

  // Host writes queue here so a burst is not lost while the core sleeps
  kbm_fifo #(
    .WIDTH(FIFO_W),
    .DEPTH(FIFO_D)
  ) u_fifo (
    .clk(MCLK),
    .reset_n(RESET_N),
    .in_valid(HOST_WR),
    .in_ready(HOST_WR_READY),
    .in_data({HOST_ADDR2, HOST_WDATA}),
    .out_valid(fifo_valid),
    .out_ready(fifo_take),
    .out_data(fifo_data)
  );

  assign push = HOST_WR && HOST_WR_READY;
  // Next byte enters only once the core has drained the last one
  assign fifo_take = fifo_valid && (!r.input_full_flag || CTL_DATA_RD);
  assign fgr_open = RESET_GATE_CONFIG[CFG_FGR_EN];

  always_comb begin
    next_r = r;
    next_r.start = 1'b0;
    next_r.wake = 1'b0;
    // Pin readback, two stages before any use
    next_r.sync1 = {MOUSE_LINK_DATA_PIN_I, MOUSE_LINK_CLK_PIN_I,
                    KBD_LINK_DATA_PIN_I, KBD_LINK_CLK_PIN_I};
    next_r.sync2 = r.sync1;
    // Port bit high pulls the pin low
    next_r.oe = {CTL_PORT2[P2_MS_DATA], CTL_PORT2[P2_MS_CLK],
                 CTL_PORT2[P2_KBD_DATA], CTL_PORT2[P2_KBD_CLK]};
    // Controller side of the mailbox
    if (CTL_DATA_RD) begin
      next_r.input_full_flag = 1'b0;
    end
    if (fifo_take) begin
      next_r.ibuf = fifo_data[7:0];
      next_r.cd = fifo_data[8];
      next_r.input_full_flag = 1'b1;
    end
    if (CTL_STATUS_WR) begin
      next_r.ud_hi = CTL_WDATA[7:4];
      next_r.ud2 = CTL_WDATA[ST_UD2];
    end
    // Host side reads
    if (HOST_RD) begin
      if (HOST_ADDR2) begin
        next_r.hrdata = CTL_STATUS;
      end else begin
        next_r.hrdata = r.obuf;
        next_r.output_full_flag = 1'b0;
      end
    end else if (HOST_FGR_RD) begin
      next_r.hrdata = fgr_open ?
        (FGR_FIXED | {6'h00, r.a20, r.rst_bit}) : FGR_LOCKED_READ;
    end
    // Set wins over the host-read clear
    if (CTL_DATA_WR) begin
      next_r.obuf = CTL_WDATA;
      next_r.output_full_flag = 1'b1;
    end
    // Fast gate/reset port writes
    if (HOST_FGR_WR && fgr_open) begin
      next_r.a20 = HOST_WDATA[FGR_A20];
      next_r.rst_bit = HOST_WDATA[FGR_RST];
    end
    case (r.ars)
      ARS_IDLE: begin
        if (next_r.rst_bit && !r.rst_bit) begin
          next_r.ars = ARS_DELAY;
          next_r.cnt = 5'(ALT_RST_DELAY_CYC - 1);
        end
      end
      ARS_DELAY: begin
        if (r.cnt == 5'h00) begin
          next_r.ars = ARS_PULSE;
          next_r.cnt = 5'(ALT_RST_WIDTH_CYC - 1);
        end else begin
          next_r.cnt = r.cnt - 5'h01;
        end
      end
      ARS_PULSE: begin
        if (r.cnt == 5'h00) begin
          next_r.ars = ARS_DONE;
        end else begin
          next_r.cnt = r.cnt - 5'h01;
        end
      end
      ARS_DONE: begin
        // Rearm only after bit 0 goes back to zero
        if (!r.rst_bit) begin
          next_r.ars = ARS_IDLE;
        end
      end
      default: begin
        next_r.ars = ARS_IDLE;
      end
    endcase
    // Power-down; a host write wakes either mode
    case (r.pwr)
      PWR_RUN: begin
        if (STOP_REQ) begin
          next_r.pwr = PWR_HARD;
        end else if (HALT_REQ) begin
          next_r.pwr = PWR_SOFT;
        end
      end
      PWR_SOFT, PWR_HARD: begin
        if (push) begin
          next_r.pwr = PWR_RUN;
          next_r.wake = IBF_IRQ_EN;
        end
      end
      default: begin
        next_r.pwr = PWR_RUN;
      end
    endcase
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      // Only reset source; pins released, status cleared
      r <= '0;
      r.a20 <= FGR_RESET[FGR_A20];
      r.rst_bit <= FGR_RESET[FGR_RST];
      r.start <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // Memories hold no reset, as on-chip arrays
  always_ff @(posedge MCLK) begin
    if (PROG_LOAD_WE) begin
      prog_mem[PROG_ADDR] <= PROG_WDATA;
    end
    if (RAM_WE) begin
      data_ram[RAM_ADDR] <= RAM_WDATA;
    end
    prog_q <= prog_mem[PROG_ADDR];
    ram_q <= data_ram[RAM_ADDR];
  end

  assign PROG_RDATA = prog_q;
  assign RAM_RDATA = ram_q;

  // Core clock is MCLK here; the 12 MHz reference divide sits upstream
  assign ALU_CLK_EN = (r.pwr == PWR_RUN);
  assign OSC_EN = (r.pwr != PWR_HARD);
  assign WAKE_CALL = r.wake;
  assign CORE_START = r.start;
  assign CORE_PC = RESET_VECTOR;
  assign IBF_IRQ = r.input_full_flag && IBF_IRQ_EN;
  assign TMR_IRQ = TIMER_OVF && TMR_IRQ_EN;

  assign CTL_IN_DATA = r.ibuf;
  assign CTL_STATUS = {r.ud_hi, r.cd, r.ud2, r.input_full_flag, r.output_full_flag};
  assign HOST_RDATA = r.hrdata;

  // Open drain: output level fixed low, enable does the driving
  assign KBD_LINK_CLK_PIN_O = 1'b0;
  assign KBD_LINK_DATA_PIN_O = 1'b0;
  assign MOUSE_LINK_CLK_PIN_O = 1'b0;
  assign MOUSE_LINK_DATA_PIN_O = 1'b0;
  assign KBD_LINK_CLK_PIN_OE = r.oe[0];
  assign KBD_LINK_DATA_PIN_OE = r.oe[1];
  assign MOUSE_LINK_CLK_PIN_OE = r.oe[2];
  assign MOUSE_LINK_DATA_PIN_OE = r.oe[3];
  assign TEST_INPUT_ZERO = r.sync2[0];
  assign PORT_BIT_KBD_DATA_IN = r.sync2[1];
  assign TEST_INPUT_ONE = r.sync2[2];
  assign PORT_BIT_MOUSE_DATA_IN = r.sync2[3];

  assign KBD_IRQ_OUT = EN_FLAGS ?
    (CTL_PORT2[P2_KBD_IRQ] && r.output_full_flag) : CTL_PORT2[P2_KBD_IRQ];
  assign MOUSE_IRQ_OUT = EN_FLAGS ?
    (CTL_PORT2[P2_MS_IRQ] && !r.input_full_flag) : CTL_PORT2[P2_MS_IRQ];
  assign ALT_ADDR20_GATE = r.a20;
  assign ALT_RESET_PULSE_N = (r.ars != ARS_PULSE);

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESET_N);

  AST_KBD_DRIVE: assert property (
    CTL_PORT2[P2_KBD_CLK] ##1 CTL_PORT2[P2_KBD_CLK] |-> KBD_LINK_CLK_PIN_OE)
    else $error("kbd clock pin not pulled low");
  AST_MS_DRIVE: assert property (
    !CTL_PORT2[P2_MS_DATA] |=> !MOUSE_LINK_DATA_PIN_OE)
    else $error("mouse data pin driven while released");
  AST_HALT: assert property (
    ALU_CLK_EN && HALT_REQ && !STOP_REQ |=> !ALU_CLK_EN && OSC_EN)
    else $error("halt did not stop only the alu clock");
  AST_WAKE: assert property (
    !ALU_CLK_EN && push |=> ALU_CLK_EN && (WAKE_CALL == $past(IBF_IRQ_EN)))
    else $error("host write did not wake the core");
  AST_IBF_LOAD: assert property (
    fifo_take |=> CTL_STATUS[ST_IBF] && (CTL_STATUS[ST_CD] == $past(fifo_data[8])))
    else $error("input load lost flag or command bit");
  AST_OBF_SET: assert property (
    CTL_DATA_WR |=> CTL_STATUS[ST_OBF] && (r.obuf == $past(CTL_WDATA)))
    else $error("controller write did not fill output buffer");
  AST_OBF_CLR: assert property (
    HOST_RD && !HOST_ADDR2 && !CTL_DATA_WR |=> !CTL_STATUS[ST_OBF])
    else $error("host read did not clear output full");
  AST_FGR_LOCK: assert property (
    HOST_FGR_WR && !fgr_open |=> $stable(ALT_ADDR20_GATE))
    else $error("locked port accepted a write");
  AST_ALT_PULSE: assert property (
    $fell(ALT_RESET_PULSE_N) |-> !ALT_RESET_PULSE_N [*8])
    else $error("alternate reset pulse too short");
  AST_ALT_DELAY: assert property (
    r.ars == ARS_IDLE && next_r.ars == ARS_DELAY |=> ALT_RESET_PULSE_N [*8])
    else $error("alternate reset pulse came early");
  AST_KBD_IRQ_OUT: assert property (
    EN_FLAGS && CTL_PORT2[P2_KBD_IRQ] && CTL_DATA_WR |=>
      KBD_IRQ_OUT || !(EN_FLAGS && CTL_PORT2[P2_KBD_IRQ]))
    else $error("kbd irq does not follow output full");
  AST_HARD: assert property (
    ALU_CLK_EN && STOP_REQ |=> !OSC_EN ##1 !OSC_EN || ALU_CLK_EN)
    else $error("stop did not halt the oscillator");

  COV_MAILBOX: cover property (push ##[1:8] CTL_DATA_RD);
  COV_WAKE: cover property (!ALU_CLK_EN ##1 push ##1 WAKE_CALL);
  COV_ALT: cover property ($fell(ALT_RESET_PULSE_N) ##[1:30] $rose(ALT_RESET_PULSE_N));
  COV_FULL: cover property (!HOST_WR_READY);
endmodule : kbm_mailbox

/* File: src/kbm_pkg.sv */
/*
  Constants and types for the keyboard controller host mailbox.
  Assumes a single 20 MHz clock feeding every user of the package.
*/
package kbm_pkg;
  // Clock and timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int CORE_CLK_KHZ = 12000;
  localparam int REF_CLK_KHZ = 14318;
  localparam int RESET_MIN_CYCLES = 24;
  localparam int ALT_RST_DELAY_NS = 500;
  localparam int ALT_RST_WIDTH_NS = 1000;
  localparam int ALT_RST_DELAY_CYC =
    (ALT_RST_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ALT_RST_WIDTH_CYC =
    (ALT_RST_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Memory sizes
  localparam int PROG_ROM_BYTES = 2048;
  localparam int DATA_RAM_BYTES = 256;
  localparam logic [10:0] RESET_VECTOR = 11'h000;
  // Status byte fields
  localparam int ST_OBF = 0;
  localparam int ST_IBF = 1;
  localparam int ST_UD2 = 2;
  localparam int ST_CD = 3;
  localparam int ST_UD_LO = 4;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // Controller port 2 bit positions
  localparam int P2_MS_DATA = 2;
  localparam int P2_MS_CLK = 3;
  localparam int P2_KBD_IRQ = 4;
  localparam int P2_MS_IRQ = 5;
  localparam int P2_KBD_CLK = 6;
  localparam int P2_KBD_DATA = 7;
  // Fast gate/reset port
  localparam logic [7:0] FGR_OFFSET = 8'h92;
  localparam logic [7:0] FGR_RESET = 8'h24;
  localparam logic [7:0] FGR_FIXED = 8'h24;
  localparam logic [7:0] FGR_LOCKED_READ = 8'hFF;
  localparam logic [7:0] CFG_OFFSET = 8'hF0;
  localparam int CFG_FGR_EN = 2;
  localparam int FGR_A20 = 1;
  localparam int FGR_RST = 0;
  // Buffering
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_WIDTH = 9;

  typedef enum logic [1:0] {
    PWR_RUN = 2'b00,
    PWR_SOFT = 2'b01,
    PWR_HARD = 2'b11
  } kbm_pwr_type;

  typedef enum logic [1:0] {
    ARS_IDLE = 2'b00,
    ARS_DELAY = 2'b01,
    ARS_PULSE = 2'b11,
    ARS_DONE = 2'b10
  } kbm_ars_type;
endpackage : kbm_pkg

/* File: verif/kbm_host_model.sv */
/*
  Host CPU model for the mailbox host side and the fast gate/reset port.
  Assumes the bench calls its tasks and shares MCLK with the design.
*/
`timescale 1ns/10ps
module kbm_host_model (
  // Clock
  input wire logic clk,
  // Host strobes
  output logic wr,
  output logic rd,
  output logic addr2,
  output logic [7:0] wdata,
  output logic fgr_wr,
  output logic fgr_rd,
  // Flow control
  input wire logic wr_ready
);
  initial begin
    wr = 1'b0;
    rd = 1'b0;
    addr2 = 1'b0;
    wdata = 8'h00;
    fgr_wr = 1'b0;
    fgr_rd = 1'b0;
  end

  // Ready is read at the taking edge, before the flops move
  task automatic host_write(input logic a2, input logic [7:0] d, output logic taken);
    @(posedge clk);
    wr <= 1'b1;
    addr2 <= a2;
    wdata <= d;
    @(posedge clk);
    taken = wr_ready;
    wr <= 1'b0;
    // Released bus must not keep showing the byte
    wdata <= d ^ 8'hFF;
  endtask : host_write

  task automatic host_read(input logic a2);
    @(posedge clk);
    rd <= 1'b1;
    addr2 <= a2;
    @(posedge clk);
    rd <= 1'b0;
  endtask : host_read

  task automatic fgr_write(input logic [7:0] d);
    @(posedge clk);
    fgr_wr <= 1'b1;
    wdata <= d;
    @(posedge clk);
    fgr_wr <= 1'b0;
    wdata <= d ^ 8'hFF;
  endtask : fgr_write

  task automatic fgr_read();
    @(posedge clk);
    fgr_rd <= 1'b1;
    @(posedge clk);
    fgr_rd <= 1'b0;
  endtask : fgr_read
endmodule : kbm_host_model

/* File: verif/test_kbm_mailbox.sv */
/*
  Self-checking bench for the keyboard controller host mailbox.
  Assumes the design package is compiled first; 20 MHz MCLK.
*/
`timescale 1ns/10ps
module test_kbm_mailbox
  import kbm_pkg::*;
;
  logic MCLK = 1'b0;
  logic RESET_N = 1'b0;
  logic HOST_WR, HOST_RD, HOST_ADDR2, HOST_FGR_WR, HOST_FGR_RD;
  logic [7:0] HOST_WDATA;
  logic CTL_DATA_WR = 0, CTL_DATA_RD = 0, CTL_STATUS_WR = 0, EN_FLAGS = 0, HALT_REQ = 0;
  logic STOP_REQ = 0, IBF_IRQ_EN = 0, TMR_IRQ_EN = 0, TIMER_OVF = 0, PROG_LOAD_WE = 0, RAM_WE = 0;
  logic [7:0] RESET_GATE_CONFIG = 0, CTL_WDATA = 0, CTL_PORT2 = 0, PROG_WDATA = 0;
  logic [7:0] RAM_ADDR = 0, RAM_WDATA = 0;
  logic [10:0] PROG_ADDR = 0;
  logic [3:0] ext = 4'h0;
  logic HOST_WR_READY, ALU_CLK_EN, OSC_EN, WAKE_CALL, CORE_START, IBF_IRQ, TMR_IRQ;
  logic [7:0] HOST_RDATA, CTL_IN_DATA, CTL_STATUS, PROG_RDATA, RAM_RDATA;
  logic [10:0] CORE_PC;
  logic KBD_LINK_CLK_PIN_O, KBD_LINK_CLK_PIN_OE, KBD_LINK_DATA_PIN_O, KBD_LINK_DATA_PIN_OE;
  logic MOUSE_LINK_CLK_PIN_O, MOUSE_LINK_CLK_PIN_OE, MOUSE_LINK_DATA_PIN_O, MOUSE_LINK_DATA_PIN_OE;
  logic TEST_INPUT_ZERO, TEST_INPUT_ONE, PORT_BIT_KBD_DATA_IN, PORT_BIT_MOUSE_DATA_IN;
  logic KBD_IRQ_OUT, MOUSE_IRQ_OUT, ALT_ADDR20_GATE, ALT_RESET_PULSE_N;
  // Pull-ups hold each line high unless a party pulls it low
  wire KBD_LINK_CLK_PIN_I = ~(KBD_LINK_CLK_PIN_OE | ext[3]);
  wire KBD_LINK_DATA_PIN_I = ~(KBD_LINK_DATA_PIN_OE | ext[2]);
  wire MOUSE_LINK_CLK_PIN_I = ~(MOUSE_LINK_CLK_PIN_OE | ext[1]);
  wire MOUSE_LINK_DATA_PIN_I = ~(MOUSE_LINK_DATA_PIN_OE | ext[0]);
  integer seed = 97;
  int mismatches = 0;
  int num_checks = 0;
  logic rd_d = 1'b0;
  logic [7:0] hq[$];
  logic [8:0] cq[$];

  kbm_mailbox DUT (.MCLK, .RESET_N, .HOST_WR, .HOST_RD, .HOST_ADDR2, .HOST_WDATA,
    .HOST_WR_READY, .HOST_RDATA, .HOST_FGR_WR, .HOST_FGR_RD, .RESET_GATE_CONFIG,
    .CTL_DATA_WR, .CTL_DATA_RD, .CTL_STATUS_WR, .CTL_WDATA, .CTL_IN_DATA, .CTL_STATUS,
    .CTL_PORT2, .EN_FLAGS, .HALT_REQ, .STOP_REQ, .IBF_IRQ_EN, .TMR_IRQ_EN, .TIMER_OVF,
    .ALU_CLK_EN, .OSC_EN, .WAKE_CALL, .CORE_START, .CORE_PC, .IBF_IRQ, .TMR_IRQ,
    .PROG_LOAD_WE, .PROG_ADDR, .PROG_WDATA, .PROG_RDATA, .RAM_WE, .RAM_ADDR, .RAM_WDATA,
    .RAM_RDATA, .KBD_LINK_CLK_PIN_I, .KBD_LINK_CLK_PIN_O, .KBD_LINK_CLK_PIN_OE,
    .KBD_LINK_DATA_PIN_I, .KBD_LINK_DATA_PIN_O, .KBD_LINK_DATA_PIN_OE,
    .MOUSE_LINK_CLK_PIN_I, .MOUSE_LINK_CLK_PIN_O, .MOUSE_LINK_CLK_PIN_OE,
    .MOUSE_LINK_DATA_PIN_I, .MOUSE_LINK_DATA_PIN_O, .MOUSE_LINK_DATA_PIN_OE,
    .TEST_INPUT_ZERO, .TEST_INPUT_ONE, .PORT_BIT_KBD_DATA_IN, .PORT_BIT_MOUSE_DATA_IN,
    .KBD_IRQ_OUT, .MOUSE_IRQ_OUT, .ALT_ADDR20_GATE, .ALT_RESET_PULSE_N);

  kbm_host_model host (.clk(MCLK), .wr(HOST_WR), .rd(HOST_RD), .addr2(HOST_ADDR2),
    .wdata(HOST_WDATA), .fgr_wr(HOST_FGR_WR), .fgr_rd(HOST_FGR_RD),
    .wr_ready(HOST_WR_READY));

  always #25 MCLK = ~MCLK;

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic print_verdict();
    if (mismatches == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict

  // Read results are judged against the oldest note in the queues
  always @(posedge MCLK) rd_d <= HOST_RD | HOST_FGR_RD;
  always @(negedge MCLK) begin
    if (rd_d) check("host_rdata", HOST_RDATA, hq.size() ? hq.pop_front() : 16'hDEAD);
    if (CTL_DATA_RD) check("ctl_in", {CTL_STATUS[ST_CD], CTL_IN_DATA},
      cq.size() ? cq.pop_front() : 16'hDEAD);
  end

  task automatic do_reset();
    @(posedge MCLK);
    RESET_N <= 1'b0;
    // Margin past the minimum also covers an oscillator restart
    repeat (RESET_MIN_CYCLES + 6) @(posedge MCLK);
    @(negedge MCLK);
    check("start", {CORE_START, ALU_CLK_EN, OSC_EN, ALT_RESET_PULSE_N}, 4'hF);
    check("pc", CORE_PC, RESET_VECTOR);
    check("st_rst", CTL_STATUS, STATUS_RESET);
    check("oe_rst", {KBD_LINK_CLK_PIN_OE, KBD_LINK_DATA_PIN_OE, MOUSE_LINK_CLK_PIN_OE,
      MOUSE_LINK_DATA_PIN_OE}, 4'h0);
    @(posedge MCLK);
    RESET_N <= 1'b1;
    @(posedge MCLK);
    @(negedge MCLK);
    check("start_end", CORE_START, 1'b0);
  endtask : do_reset

  task automatic ctl_read();
    @(posedge MCLK);
    CTL_DATA_RD <= 1'b1;
    @(posedge MCLK);
    CTL_DATA_RD <= 1'b0;
    @(negedge MCLK);
  endtask : ctl_read

  task automatic drain();
    int g;
    g = 0;
    // Mailbox fills one cycle after the byte enters the queue
    @(negedge MCLK);
    while (CTL_STATUS[ST_IBF] === 1'b1 && g < 40) begin
      ctl_read();
      g++;
    end
    check("drained", {cq.size() == 0, CTL_STATUS[ST_IBF], IBF_IRQ}, 3'b100);
  endtask : drain

  task automatic pulse(output int dly, output int wid);
    dly = 0;
    wid = 0;
    while (ALT_RESET_PULSE_N !== 1'b0 && dly < 60) begin
      @(negedge MCLK);
      dly++;
    end
    while (ALT_RESET_PULSE_N === 1'b0 && wid < 60) begin
      @(negedge MCLK);
      wid++;
    end
  endtask : pulse

  task automatic power(input logic stop, input logic en);
    logic t;
    @(posedge MCLK);
    HALT_REQ <= !stop;
    STOP_REQ <= stop;
    IBF_IRQ_EN <= en;
    @(posedge MCLK);
    HALT_REQ <= 1'b0;
    STOP_REQ <= 1'b0;
    @(negedge MCLK);
    check("down", {ALU_CLK_EN, OSC_EN}, {1'b0, !stop});
    host.host_write(1'b0, 8'h5A, t);
    cq.push_back(9'h05A);
    @(negedge MCLK);
    check("wake", {ALU_CLK_EN, OSC_EN, WAKE_CALL}, {2'b11, en});
    drain();
  endtask : power

  initial begin
    int i, n, dly, wid;
    logic t, a, c;
    logic [7:0] d;
    logic [3:0] oe;
    do_reset();
    // Link pins against random port bits and far-end pulls
    for (i = 0; i < 8; i++) begin
      @(posedge MCLK);
      CTL_PORT2 <= $random(seed);
      ext <= $random(seed);
      repeat (4) @(posedge MCLK);
      @(negedge MCLK);
      oe = {CTL_PORT2[P2_KBD_CLK], CTL_PORT2[P2_KBD_DATA], CTL_PORT2[P2_MS_CLK],
        CTL_PORT2[P2_MS_DATA]};
      check("oe", {KBD_LINK_CLK_PIN_OE, KBD_LINK_DATA_PIN_OE, MOUSE_LINK_CLK_PIN_OE,
        MOUSE_LINK_DATA_PIN_OE}, oe);
      check("o", {KBD_LINK_CLK_PIN_O, KBD_LINK_DATA_PIN_O, MOUSE_LINK_CLK_PIN_O,
        MOUSE_LINK_DATA_PIN_O}, 4'h0);
      check("rdbk", {TEST_INPUT_ZERO, PORT_BIT_KBD_DATA_IN, TEST_INPUT_ONE,
        PORT_BIT_MOUSE_DATA_IN}, (oe | ext) ^ 4'hF);
      check("kbd_irq_out_raw", KBD_IRQ_OUT, CTL_PORT2[P2_KBD_IRQ]);
    end
    // Fill until refused with the controller stalled, then drain in order
    @(posedge MCLK);
    // Mouse irq bit up, so gating shows input-full inverted
    CTL_PORT2 <= 8'h20;
    EN_FLAGS <= 1'b1;
    IBF_IRQ_EN <= 1'b1;
    n = 0;
    t = 1'b1;
    while (t === 1'b1 && n < 40) begin
      d = $random(seed);
      a = $random(seed);
      host.host_write(a, d, t);
      if (t === 1'b1) begin
        cq.push_back({a, d});
        n++;
        c = a;
      end
    end
    check("fill", n, FIFO_DEPTH + 1);
    check("ibf_irq", {CTL_STATUS[ST_IBF], IBF_IRQ, MOUSE_IRQ_OUT}, 3'b110);
    drain();
    check("mouse_irq_out", MOUSE_IRQ_OUT, 1'b1);
    // Output buffer under each flag gating combination
    for (i = 0; i < 4; i++) begin
      d = $random(seed);
      @(posedge MCLK);
      EN_FLAGS <= i[0];
      CTL_PORT2[P2_KBD_IRQ] <= i[1];
      CTL_DATA_WR <= 1'b1;
      CTL_WDATA <= d;
      @(posedge MCLK);
      CTL_DATA_WR <= 1'b0;
      @(negedge MCLK);
      check("obf", {CTL_STATUS[ST_OBF], KBD_IRQ_OUT}, {1'b1, i[1]});
      hq.push_back(d);
      host.host_read(1'b0);
      @(negedge MCLK);
      check("obf_clr", {CTL_STATUS[ST_OBF], KBD_IRQ_OUT}, {1'b0, i[1] & !i[0]});
    end
    // Controller writes status; flags stay as they were
    d = $random(seed);
    @(posedge MCLK);
    CTL_STATUS_WR <= 1'b1;
    CTL_WDATA <= d;
    @(posedge MCLK);
    CTL_STATUS_WR <= 1'b0;
    @(negedge MCLK);
    check("status", CTL_STATUS, (d & 8'hF4) | {4'h0, c, 3'b000});
    hq.push_back((d & 8'hF4) | {4'h0, c, 3'b000});
    host.host_read(1'b1);
    for (i = 0; i < 4; i++) begin
      @(posedge MCLK);
      TIMER_OVF <= i[0];
      TMR_IRQ_EN <= i[1];
      @(negedge MCLK);
      check("tmr_irq", TMR_IRQ, i[0] & i[1]);
    end
    // Program store and data RAM at random addresses; a write with enables low must not land
    d = $random(seed);
    @(posedge MCLK);
    RAM_ADDR <= $random(seed);
    PROG_ADDR <= $random(seed);
    for (i = 0; i < 2; i++) begin
      @(posedge MCLK);
      RAM_WE <= !i[0];
      PROG_LOAD_WE <= !i[0];
      RAM_WDATA <= d ^ {8{i[0]}};
      PROG_WDATA <= ~d ^ {8{i[0]}};
      @(posedge MCLK);
      RAM_WE <= 1'b0;
      PROG_LOAD_WE <= 1'b0;
      @(posedge MCLK);
      @(negedge MCLK);
      check("mem", {RAM_RDATA, PROG_RDATA}, {d, ~d});
    end
    // Fast gate/reset port, closed then open
    host.fgr_write(8'h03);
    hq.push_back(FGR_LOCKED_READ);
    host.fgr_read();
    @(posedge MCLK);
    RESET_GATE_CONFIG <= $random(seed) | 8'h04;
    hq.push_back(FGR_RESET);
    host.fgr_read();
    host.fgr_write(8'h02);
    hq.push_back(FGR_FIXED | 8'h02);
    host.fgr_read();
    @(negedge MCLK);
    check("a20", ALT_ADDR20_GATE, 1'b1);
    host.fgr_write(8'h01);
    pulse(dly, wid);
    check("a20_lo", ALT_ADDR20_GATE, 1'b0);
    check("rst_dly", dly >= ALT_RST_DELAY_CYC && dly <= ALT_RST_DELAY_CYC + 2, 1'b1);
    check("rst_wid", wid, ALT_RST_WIDTH_CYC);
    host.fgr_write(8'h01);
    pulse(dly, wid);
    check("no_rearm", wid, 0);
    host.fgr_write(8'h00);
    host.fgr_write(8'h01);
    pulse(dly, wid);
    check("rearm", wid, ALT_RST_WIDTH_CYC);
    // Power-down and its exits
    power(1'b0, 1'b1);
    power(1'b1, 1'b0);
    @(posedge MCLK);
    HALT_REQ <= 1'b1;
    @(posedge MCLK);
    HALT_REQ <= 1'b0;
    do_reset();
    check("run", ALU_CLK_EN, 1'b1);
    print_verdict();
  end

  // Whole run is a few hundred cycles
  initial begin
    repeat (20000) @(posedge MCLK);
    mismatches++;
    print_verdict();
  end
endmodule : test_kbm_mailbox
